// ==== bemp_top.sv ====
// Enable sequencing, mode selection, strap decode and output-ok control
`timescale 1ns/1ps
`include "bemp_map.svh"
module bemp_top
   import bemp_pkg::*;
#(
   parameter int DELAY_CYC = `BEMP_CYC(`BEMP_T_DELAY_US),
   parameter int SS_CYC = `BEMP_CYC(`BEMP_T_SS_US),
   parameter int ACT_CYC = `BEMP_CYC(`BEMP_T_ACT_US),
   parameter int FIRST_CYC = `BEMP_CYC(`BEMP_T_FIRST_US),
   parameter int MODE_CYC = `BEMP_CYC(`BEMP_T_MODE_US),
   parameter int FILT_CYC = `BEMP_CYC(`BEMP_T_FILT_US),
   parameter int SYNC_MAX_CYC = 400
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Enable comparators
   input wire logic en_wake,
   input wire logic en_vout,
   input wire logic en_hyst_low,
   // Mode pin and strap
   input wire logic mode_pin,
   input wire logic [1:0] freq_strap_pin,
   // Monitors
   input wire logic vout_uv,
   input wire logic vout_ov,
   input wire logic vout_in_reg,
   input wire logic overtemp_trip,
   input wire logic overtemp_recover,
   input wire logic internal_supply_lockout,
   input wire logic ok_valid_supply_level,
   input wire logic fault_ilim,
   // Timing limit and oscillator tick from the power stage
   input wire logic on_off_limited,
   input wire logic osc_tick,
   // Power control
   output logic shutdown,
   output logic ldo_on,
   output logic switching,
   output logic ss_active,
   // Mode outputs
   output bemp_mode_t mode,
   output logic diode_emul,
   output logic light_load_pulse_skip,
   output logic continuous_conduction,
   output logic forced_continuous_mode,
   output logic spread_en,
   output logic foldback_en,
   output logic hs_on,
   output logic clk_from_sync,
   output bemp_freq_t freq_sel,
   // Output-ok pin
   output logic output_ok_flag,
   output logic output_ok_pin_o,
   output logic output_ok_pin_oe
);
   // ==========================================================
   // Input synchronisers
   localparam int NS = 14;
   logic [NS-1:0] raw;
   logic [NS-1:0] s;
   assign raw = {fault_ilim, ok_valid_supply_level, internal_supply_lockout,
                 overtemp_recover, overtemp_trip, vout_in_reg, vout_ov, vout_uv,
                 freq_strap_pin, mode_pin, en_hyst_low, en_vout, en_wake};
   bemp_sync2 #(.W(NS)) u_sync (.mclk(mclk), .srst(srst), .d(raw), .q(s));
   wire wake_s = s[0];
   wire vout_s = s[1];
   wire hyst_low_s = s[2];
   wire mode_s = s[3];
   wire [1:0] strap_s = s[5:4];
   wire ot_trip_s = s[9];
   wire ot_rec_s = s[10];
   wire uvlo_s = s[11];
   wire valid_s = s[12];
   wire ilim_s = s[13];

   bemp_sync_if mon_if ();
   assign mon_if.uv = s[6];
   assign mon_if.ov = s[7];
   assign mon_if.in_reg = s[8];
   logic uv_f;
   logic ov_f;
   bemp_filt #(.FILT_CYC(FILT_CYC)) u_filt (.mclk(mclk), .srst(srst), .mon(mon_if),
      .uv_f(uv_f), .ov_f(ov_f));

   // ==========================================================
   // Enable sequencer
   bemp_seq_t seq_r;
   bemp_seq_t seq_nxt;
   logic [17:0] seq_cnt_r;
   logic [17:0] ss_time_r;
   logic [17:0] first_cnt_r;
   logic first_done_r;
   logic ot_r;
   wire ot_hold = ot_trip_s || (ot_r && !ot_rec_s);
   wire run_ok = vout_s && !uvlo_s && !ot_hold;
   wire dly_end = (seq_cnt_r >= 18'(DELAY_CYC - 1));
   wire ss_end = (seq_cnt_r >= 18'(SS_CYC - 1));
   wire ss_elapsed = (ss_time_r >= 18'(SS_CYC));

   always_comb
   begin
      seq_nxt = seq_r;
      case (seq_r)
         BEMP_OFF: if (wake_s) seq_nxt = BEMP_STANDBY;
         BEMP_STANDBY: if (run_ok) seq_nxt = BEMP_DELAY;
         BEMP_DELAY: if (dly_end) seq_nxt = BEMP_RAMP;
         BEMP_RAMP: if (ss_end) seq_nxt = BEMP_RUN;
         BEMP_RUN: seq_nxt = BEMP_RUN;
         default: seq_nxt = BEMP_OFF;
      endcase
      // Falling enable or lockout stops switching
      if (seq_r != BEMP_OFF && seq_r != BEMP_STANDBY && (hyst_low_s || uvlo_s || ot_hold))
         seq_nxt = BEMP_STANDBY;
      if (!wake_s)
         seq_nxt = BEMP_OFF;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         seq_r <= BEMP_OFF;
         seq_cnt_r <= 18'h00000;
         ss_time_r <= 18'h00000;
         ot_r <= 1'b0;
      end
      else
      begin
         seq_r <= seq_nxt;
         ot_r <= ot_hold;
         seq_cnt_r <= (seq_nxt != seq_r) ? 18'h00000 : seq_cnt_r + 18'h00001;
         // Soft-start time counts from the enable edge, saturating
         if (seq_r == BEMP_STANDBY || seq_r == BEMP_OFF)
            ss_time_r <= 18'h00000;
         else if (!ss_elapsed)
            ss_time_r <= ss_time_r + 18'h00001;
      end
   end

   assign shutdown = (seq_r == BEMP_OFF);
   assign ldo_on = !shutdown;
   assign switching = (seq_r == BEMP_DELAY) || (seq_r == BEMP_RAMP) || (seq_r == BEMP_RUN);
   assign ss_active = (seq_r == BEMP_DELAY) || (seq_r == BEMP_RAMP);

   // ==========================================================
   // Mode pin decode
   logic mode_d_r;
   logic [15:0] stable_r;
   logic [15:0] per_r;
   logic [2:0] edges_r;
   bemp_mode_t pin_mode_r;
   wire mode_rise = mode_s && !mode_d_r;
   wire mode_chg = mode_s != mode_d_r;
   wire steady = (stable_r >= 16'(MODE_CYC));
   wire per_ok = (per_r <= 16'(SYNC_MAX_CYC));
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         mode_d_r <= 1'b0;
         stable_r <= 16'h0000;
         per_r <= 16'h0000;
         edges_r <= 3'h0;
         pin_mode_r <= BEMP_AUTO;
      end
      else
      begin
         mode_d_r <= mode_s;
         stable_r <= mode_chg ? 16'h0000 : (steady ? stable_r : stable_r + 16'h0001);
         per_r <= mode_rise ? 16'h0000 : (per_ok ? per_r + 16'h0001 : per_r);
         if (mode_rise)
            edges_r <= per_ok ? ((edges_r == `BEMP_SYNC_MIN_EDGES) ? edges_r : edges_r + 3'h1) : 3'h1;
         else if (steady)
            edges_r <= 3'h0;
         if (steady)
            pin_mode_r <= mode_s ? BEMP_FORCED : BEMP_AUTO;
         else if (edges_r == `BEMP_SYNC_MIN_EDGES)
            pin_mode_r <= BEMP_SYNC;
      end
   end

   // Start-up forces auto until the ramp has ended and the soft-start time has passed
   wire hold_auto = ss_active || !ss_elapsed;
   assign mode = hold_auto ? BEMP_AUTO : pin_mode_r;
   wire cont = (mode == BEMP_FORCED) || (mode == BEMP_SYNC);
   assign diode_emul = !cont;
   assign light_load_pulse_skip = (mode == BEMP_AUTO);
   assign continuous_conduction = cont && switching;
   assign forced_continuous_mode = cont;
   assign spread_en = (mode != BEMP_SYNC);
   assign foldback_en = 1'b1;
   // Follow the sync clock only if on/off time limits allow it
   assign clk_from_sync = (mode == BEMP_SYNC) && !on_off_limited;
   logic hs_on_r;
   always_ff @(posedge mclk)
   begin
      if (srst)
         hs_on_r <= 1'b0;
      else
         hs_on_r <= switching && (clk_from_sync ? mode_rise : osc_tick);
   end
   assign hs_on = hs_on_r;

   // ==========================================================
   // Frequency strap
   logic [1:0] strap_r;
   always_ff @(posedge mclk)
   begin
      if (srst)
         strap_r <= `BEMP_STRAP_FLOAT;
      else
         strap_r <= strap_s;
   end
   assign freq_sel = (strap_r == `BEMP_STRAP_VCC) ? BEMP_F_1M :
                     (strap_r == `BEMP_STRAP_GND) ? BEMP_F_2M2 :
                     (strap_r == `BEMP_STRAP_RES) ? BEMP_F_ADJ : BEMP_F_NONE;

   // ==========================================================
   // Output-ok flag
   logic [17:0] act_r;
   logic ok_r;
   wire fault = uv_f || ov_f || ot_hold || hyst_low_s || !wake_s || uvlo_s || ilim_s
                || ss_active || (seq_r != BEMP_RUN);
   wire can_go = !fault && mon_if.in_reg && vout_s;
   wire act_end = (act_r >= 18'(ACT_CYC));
   wire first_end = (first_cnt_r >= 18'(FIRST_CYC));
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         act_r <= 18'h00000;
         ok_r <= 1'b0;
         first_cnt_r <= 18'h00000;
         first_done_r <= 1'b0;
      end
      else
      begin
         act_r <= can_go ? (act_end ? act_r : act_r + 18'h00001) : 18'h00000;
         // Initial delay counted once from the first output-enable crossing
         if (!first_done_r && switching && !first_end)
            first_cnt_r <= first_cnt_r + 18'h00001;
         if (ok_r)
            first_done_r <= 1'b1;
         ok_r <= can_go && act_end && (first_done_r || first_end);
      end
   end
   // Pull-down needs enough supply to hold the pin low
   assign output_ok_flag = ok_r;
   assign output_ok_pin_o = 1'b0;
   assign output_ok_pin_oe = !ok_r && valid_s;
endmodule : bemp_top

// ==== bemp_map.svh ====
// Constant map of the buck enable, mode and output-ok control block
`ifndef BEMP_MAP_SVH
`define BEMP_MAP_SVH
`define BEMP_CLK_HZ 40000000
`define BEMP_T_DELAY_US 1000
`define BEMP_T_SS_US 2670
`define BEMP_T_ACT_US 2000
`define BEMP_T_FIRST_US 5000
`define BEMP_T_FILT_US 20
`define BEMP_T_MODE_US 20
`define BEMP_CYC(us) ((`BEMP_CLK_HZ / 1000000) * (us))
`define BEMP_SYNC_MIN_EDGES 3'h3
`define BEMP_STRAP_VCC 2'h0
`define BEMP_STRAP_GND 2'h1
`define BEMP_STRAP_RES 2'h2
`define BEMP_STRAP_FLOAT 2'h3
`endif

// ==== bemp_pkg.sv ====
// Types of the buck enable, mode and output-ok control block
package bemp_pkg;
   typedef enum logic [2:0] {BEMP_OFF, BEMP_STANDBY, BEMP_DELAY, BEMP_RAMP, BEMP_RUN} bemp_seq_t;
   typedef enum logic [1:0] {BEMP_AUTO, BEMP_FORCED, BEMP_SYNC} bemp_mode_t;
   typedef enum logic [1:0] {BEMP_F_1M, BEMP_F_2M2, BEMP_F_ADJ, BEMP_F_NONE} bemp_freq_t;
endpackage : bemp_pkg

// ==== bemp_sync_if.sv ====
// Bundle of synchronised comparator levels shared with the filter
`timescale 1ns/1ps
interface bemp_sync_if;
   logic uv;
   logic ov;
   logic in_reg;
   modport src (output uv, output ov, output in_reg);
   modport dst (input uv, input ov, input in_reg);
endinterface : bemp_sync_if

// ==== bemp_sync2.sv ====
// Two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
module bemp_sync2 #(parameter int W = 1)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Level in and out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         meta_r <= '0;
         q <= '0;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : bemp_sync2

// ==== bemp_filt.sv ====
// Deglitch filter of the output voltage monitor
`timescale 1ns/1ps
`include "bemp_map.svh"
module bemp_filt #(parameter int FILT_CYC = `BEMP_CYC(`BEMP_T_FILT_US))
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Raw synchronised levels
   bemp_sync_if.dst mon,
   // Filtered faults
   output logic uv_f,
   output logic ov_f
);
   logic [15:0] uv_cnt_r;
   logic [15:0] ov_cnt_r;
   wire uv_done = (uv_cnt_r >= 16'(FILT_CYC));
   wire ov_done = (ov_cnt_r >= 16'(FILT_CYC));
   // Fault sets only after a full filter time; clears on regulation
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         uv_cnt_r <= 16'h0000;
         ov_cnt_r <= 16'h0000;
         uv_f <= 1'b0;
         ov_f <= 1'b0;
      end
      else
      begin
         uv_cnt_r <= mon.uv ? (uv_done ? uv_cnt_r : uv_cnt_r + 16'h0001) : 16'h0000;
         ov_cnt_r <= mon.ov ? (ov_done ? ov_cnt_r : ov_cnt_r + 16'h0001) : 16'h0000;
         uv_f <= (mon.uv && uv_done) || (uv_f && !mon.in_reg);
         ov_f <= (mon.ov && ov_done) || (ov_f && !mon.in_reg);
      end
   end
endmodule : bemp_filt

// ==== bemp_props.sv ====
// Concurrent checks on the ports of the enable, mode and output-ok block
`timescale 1ns/1ps
module bemp_props
   import bemp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Watched inputs
   input wire logic en_wake,
   input wire logic en_hyst_low,
   input wire logic fault_ilim,
   input wire logic [1:0] freq_strap_pin,
   // Power control
   input wire logic shutdown,
   input wire logic ldo_on,
   input wire logic switching,
   input wire logic ss_active,
   // Mode outputs
   input wire bemp_mode_t mode,
   input wire logic diode_emul,
   input wire logic light_load_pulse_skip,
   input wire logic continuous_conduction,
   input wire logic forced_continuous_mode,
   input wire logic foldback_en,
   input wire logic clk_from_sync,
   input wire bemp_freq_t freq_sel,
   // Output-ok
   input wire logic output_ok_flag,
   input wire logic output_ok_pin_oe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // ==========================================
   // Sequences
   // Lengths cover the two-flop input latency plus one register
   sequence en_off_s;
      (!en_wake) [*4];
   endsequence
   sequence en_band_s;
      (en_wake && en_hyst_low) [*5];
   endsequence
   sequence strap_still_s;
      $stable(freq_strap_pin) [*4];
   endsequence
   // ==========================================
   // Assertions
   off_state_a: assert property (en_off_s |-> shutdown && !ldo_on && !switching)
      else $error("block not off with enable low");
   standby_idle_a: assert property (en_band_s |-> ldo_on && !switching)
      else $error("switching while in standby");
   ramp_auto_a: assert property (ss_active |-> mode == BEMP_AUTO && diode_emul)
      else $error("non-auto mode during soft start");
   sync_conduct_a: assert property (mode == BEMP_SYNC |-> !diode_emul && continuous_conduction
      && clk_from_sync)
      else $error("sync mode without continuous conduction");
   auto_skip_a: assert property (mode == BEMP_AUTO && switching |-> diode_emul
      && light_load_pulse_skip)
      else $error("auto mode without pulse skip");
   forced_cont_a: assert property (mode == BEMP_FORCED |-> !diode_emul && forced_continuous_mode
      && continuous_conduction)
      else $error("forced mode with diode emulation");
   foldback_kept_a: assert property (clk_from_sync |-> foldback_en)
      else $error("foldback lost on external clock");
   strap_decode_a: assert property (strap_still_s |-> freq_sel == bemp_freq_t'(freq_strap_pin))
      else $error("strap decode wrong");
   ok_en_low_a: assert property (en_hyst_low [*5] |-> !output_ok_flag)
      else $error("output ok high with enable low");
   ok_fault_a: assert property (fault_ilim [*4] |-> !output_ok_flag)
      else $error("output ok high in current limit");
   ok_ramp_a: assert property (ss_active |-> !output_ok_flag && output_ok_pin_oe)
      else $error("output ok released in soft start");
   ok_pin_a: assert property (output_ok_flag |-> !output_ok_pin_oe)
      else $error("pin pulled low while flag high");
endmodule : bemp_props

bind bemp_top bemp_props u_props (.*);

// ==== bemp_host.sv ====
// Host model driving enable comparators and the mode pin
`timescale 1ns/1ps
module bemp_host
(
   // Commands from the bench
   input wire logic [1:0] en_lvl,
   input wire logic sync_on,
   input wire logic mode_lvl,
   // Pins toward the block
   output logic en_wake,
   output logic en_vout,
   output logic en_hyst_low,
   output logic mode_pin
);
   logic sync_clk = 1'b0;
   // Fixed phase against mclk; gated onto the pin only on request
   always #100 sync_clk = ~sync_clk;
   // Level 1 sits in the hysteresis band below output-enable
   assign en_wake = en_lvl != 2'h0;
   assign en_vout = en_lvl == 2'h3;
   assign en_hyst_low = en_lvl != 2'h3;
   assign mode_pin = sync_on ? sync_clk : mode_lvl;
endmodule : bemp_host

// ==== tb_bemp_top.sv ====
// Self-checking bench of the enable, mode and output-ok block
`timescale 1ns/1ps
module tb_bemp_top
   import bemp_pkg::*;
;
   localparam int ACT = 40;
   localparam int FIRST = 120;
   logic mclk = 1'b0, srst, en_wake, en_vout, en_hyst_low, mode_pin, vout_uv, vout_ov;
   logic vout_in_reg, overtemp_trip, overtemp_recover, internal_supply_lockout;
   logic ok_valid_supply_level, fault_ilim, on_off_limited, osc_tick, sync_on, mode_lvl;
   logic [1:0] freq_strap_pin, en_lvl;
   logic shutdown, ldo_on, switching, ss_active, diode_emul, light_load_pulse_skip;
   logic continuous_conduction, forced_continuous_mode, spread_en, foldback_en, hs_on;
   logic clk_from_sync, output_ok_flag, output_ok_pin_o, output_ok_pin_oe;
   bemp_mode_t mode;
   bemp_freq_t freq_sel;
   int mismatches = 0;
   int num_checks = 0;
   int n;
   bemp_top #(.DELAY_CYC(20), .SS_CYC(50), .ACT_CYC(ACT), .FIRST_CYC(FIRST), .MODE_CYC(10),
      .FILT_CYC(4), .SYNC_MAX_CYC(16)) dut (.*);
   bemp_host host (.*);
   // ==========================================
   // Clock and helpers
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) osc_tick <= #2 ~osc_tick;
   task cyc(input int k);
      repeat (k) @(posedge mclk);
      #2;
   endtask : cyc
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task stop_test;
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test
   // ==========================================
   // Scenarios
   task t_strap;
      for (int i = 0; i < 4; i++)
      begin
         freq_strap_pin = 2'(i);
         cyc(5);
         chk(freq_sel, 8'(i));
      end
      freq_strap_pin = 2'h0;
      chk(shutdown, 1'b1);
   endtask : t_strap
   task t_start;
      // Sync runs from standby on, so the ramp must refuse it
      sync_on = 1'b1;
      en_lvl = 2'h1;
      cyc(6);
      chk({ldo_on, switching}, 2'b10);
      en_lvl = 2'h3;
      n = 0;
      while (output_ok_flag !== 1'b1 && n < 400)
      begin
         if (ss_active === 1'b1)
            chk(mode, BEMP_AUTO);
         cyc(1);
         n++;
      end
      chk(n >= FIRST && n <= FIRST + 10, 1'b1);
      chk(mode, BEMP_SYNC);
      chk({spread_en, clk_from_sync}, 2'b01);
      n = 0;
      repeat (80)
      begin
         cyc(1);
         n += int'(hs_on === 1'b1);
      end
      chk(n >= 9 && n <= 11, 1'b1);
   endtask : t_start
   task t_modes;
      sync_on = 1'b0;
      mode_lvl = 1'b1;
      cyc(20);
      chk({mode, diode_emul}, {BEMP_FORCED, 1'b0});
      mode_lvl = 1'b0;
      cyc(20);
      chk({mode, diode_emul}, {BEMP_AUTO, 1'b1});
   endtask : t_modes
   task t_faults;
      vout_uv = 1'b1;
      cyc(2);
      vout_uv = 1'b0;
      cyc(8);
      chk(output_ok_flag, 1'b1);
      vout_ov = 1'b1;
      vout_in_reg = 1'b0;
      cyc(10);
      chk(output_ok_flag, 1'b0);
      vout_ov = 1'b0;
      vout_in_reg = 1'b1;
      n = 0;
      while (output_ok_flag !== 1'b1 && n < 200)
      begin
         cyc(1);
         n++;
      end
      chk(n >= ACT && n <= ACT + 10, 1'b1);
      fault_ilim = 1'b1;
      cyc(6);
      chk(output_ok_flag, 1'b0);
      fault_ilim = 1'b0;
      cyc(60);
      chk(output_ok_flag, 1'b1);
   endtask : t_faults
   task t_shut;
      en_lvl = 2'h1;
      cyc(6);
      chk({switching, ldo_on, output_ok_flag}, 3'b010);
      chk({output_ok_pin_oe, output_ok_pin_o}, 2'b10);
      en_lvl = 2'h0;
      cyc(6);
      chk(shutdown, 1'b1);
   endtask : t_shut
   // ==========================================
   // Main sequence and watchdog
   initial
   begin
      srst = 1'b1;
      {vout_uv, vout_ov, overtemp_trip, internal_supply_lockout, fault_ilim} = 5'h00;
      {vout_in_reg, overtemp_recover, ok_valid_supply_level} = 3'h7;
      {on_off_limited, osc_tick, sync_on, mode_lvl} = 4'h0;
      freq_strap_pin = 2'h0;
      en_lvl = 2'h0;
      cyc(20);
      srst = 1'b0;
      t_strap();
      t_start();
      t_modes();
      t_faults();
      t_shut();
      stop_test();
   end
   initial
   begin
      #(25 * 3000);
      mismatches++;
      stop_test();
   end
endmodule : tb_bemp_top
